// ---- hdl/ldo_sequence_fault_supervisor.sv ----
`include "ldo_supervisor_defines.svh"
`default_nettype none
module ldo_sequence_fault_supervisor #(
  parameter int TW = 20,
  parameter int RESTART_CYC = `RESTART_CYC,
  parameter int START_WIN_CYC = `START_WIN_CYC,
  parameter int OC_QUAL_CYC = `OC_QUAL_CYC,
  parameter int SLOT_CYC = `SLOT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ldo_supervisor_pkg::monitor_t monitor,
  output logic [6:0] channel_on,
  output logic interrupt_out_n
);
  localparam int N = `NUM_CH;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  ldo_supervisor_pkg::monitor_t mon_meta;
  ldo_supervisor_pkg::monitor_t mon;
  logic sys_prev;
  logic ot_prev;

  // Two flops, nothing reads the first but the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_meta <= '0;
      mon <= '0;
      sys_prev <= 1'b0;
      ot_prev <= 1'b0;
    end else begin
      mon_meta <= monitor;
      mon <= mon_meta;
      sys_prev <= mon.sys_lockout;
      ot_prev <= mon.over_temp;
    end
  end

  // ==========================================================
  // Wishbone decode
  // ==========================================================
  logic [31:0] ctrl;
  wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = access & wb_we_i & wb_sel_i[0];
  wire rd = access & ~wb_we_i;
  wire [5:0] idx = wb_adr_i[7:2];
  wire wr_ctrl = wr & (idx == `REG_CTRL);
  wire wr_en = wr & (idx == `REG_ENABLE);
  wire wr_slot = wr & (idx == `REG_SLOTS) & (&wb_sel_i[2:0]);
  wire rd_uvp = rd & (idx == `REG_UVP_INT);
  wire rd_oc = rd & (idx == `REG_OC_INT);
  wire rd_lock = rd & (idx == `REG_LOCK_INT);
  wire sys_en = ctrl[`CTRL_SYS_EN];
  wire inhibit = ctrl[`CTRL_INHIBIT];
  wire [1:0] seq_cmd = wb_dat_i[`CTRL_SEQ_LSB +: 2];
  wire cmd_up = wr_ctrl & (seq_cmd == `SEQ_CMD_UP);
  wire cmd_down = wr_ctrl & (seq_cmd == `SEQ_CMD_DOWN);

  // Control register; command field is a strobe, never stored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      ctrl <= {30'h0, wb_dat_i[`CTRL_INHIBIT], wb_dat_i[`CTRL_SYS_EN]};
    end
  end

  // ==========================================================
  // Chip-level lockout and over-temperature
  // ==========================================================
  ldo_supervisor_pkg::chip_state_t chip_st;
  logic [TW-1:0] chip_tmr;
  logic [2:0] chip_cnt;
  logic sys_int;
  logic ot_int;
  wire chip_trig = mon.sys_lockout | mon.over_temp;
  wire chip_ok = (chip_st == ldo_supervisor_pkg::CHIP_OK);
  wire chip_held = chip_tmr >= TW'(RESTART_CYC - 1);

  // Hold all channels off; fourth counted event is final
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_st <= ldo_supervisor_pkg::CHIP_OK;
      chip_tmr <= '0;
      chip_cnt <= '0;
    end else begin
      case (chip_st)
        ldo_supervisor_pkg::CHIP_OK: begin
          chip_tmr <= '0;
          if (chip_trig) begin
            chip_st <= ldo_supervisor_pkg::CHIP_HOLD;
            if (!inhibit) begin
              chip_cnt <= chip_cnt + 3'h1;
              if (chip_cnt + 3'h1 == `CHIP_FAULT_MAX) begin
                chip_st <= ldo_supervisor_pkg::CHIP_DEAD;
              end
            end
          end
        end
        ldo_supervisor_pkg::CHIP_HOLD: begin
          if (!chip_held) begin
            chip_tmr <= chip_tmr + TW'(1);
          end
          // Inhibit restarts as soon as the cause is gone
          if (!chip_trig && (inhibit || chip_held)) begin
            chip_st <= ldo_supervisor_pkg::CHIP_OK;
          end
        end
        ldo_supervisor_pkg::CHIP_DEAD: begin
          chip_st <= ldo_supervisor_pkg::CHIP_DEAD;
        end
        default: begin
          chip_st <= ldo_supervisor_pkg::CHIP_OK;
        end
      endcase
    end
  end

  // Chip interrupts: set on rising cause, read clears, set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_int <= 1'b0;
      ot_int <= 1'b0;
    end else begin
      if (rd_lock) begin
        sys_int <= 1'b0;
        ot_int <= 1'b0;
      end
      if (mon.sys_lockout && !sys_prev) begin
        sys_int <= 1'b1;
      end
      if (mon.over_temp && !ot_prev) begin
        ot_int <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Slot sequencer
  // ==========================================================
  ldo_supervisor_pkg::seq_state_t seq_st;
  logic [2:0] seq_cnt;
  logic [TW-1:0] seq_tmr;
  logic [3*N-1:0] slots;
  wire seq_stop = !sys_en || !chip_ok;
  wire slot_end = seq_tmr >= TW'(SLOT_CYC - 1);
  wire seq_up = (seq_st == ldo_supervisor_pkg::SEQ_UP);
  wire seq_down = (seq_st == ldo_supervisor_pkg::SEQ_DOWN);

  // Up walks slots 1..7, down walks 7..1
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_st <= ldo_supervisor_pkg::SEQ_IDLE;
      seq_cnt <= `SLOT_NONE;
      seq_tmr <= '0;
    end else if (seq_stop) begin
      seq_st <= ldo_supervisor_pkg::SEQ_IDLE;
      seq_cnt <= `SLOT_NONE;
    end else if (cmd_up || cmd_down) begin
      seq_st <= cmd_up ? ldo_supervisor_pkg::SEQ_UP : ldo_supervisor_pkg::SEQ_DOWN;
      seq_cnt <= cmd_up ? `SLOT_FIRST : `SLOT_LAST;
      seq_tmr <= '0;
    end else begin
      case (seq_st)
        ldo_supervisor_pkg::SEQ_UP,
        ldo_supervisor_pkg::SEQ_DOWN: begin
          seq_tmr <= slot_end ? '0 : seq_tmr + TW'(1);
          if (slot_end) begin
            if ((seq_up && seq_cnt == `SLOT_LAST) ||
                (seq_down && seq_cnt == `SLOT_FIRST)) begin
              seq_st <= ldo_supervisor_pkg::SEQ_IDLE;
              seq_cnt <= `SLOT_NONE;
            end else begin
              seq_cnt <= seq_up ? seq_cnt + 3'h1 : seq_cnt - 3'h1;
            end
          end
        end
        default: begin
          seq_st <= ldo_supervisor_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Per-channel fault supervisor
  // ==========================================================
  logic [N-1:0] en;
  logic [N-1:0] susd;
  logic [N-1:0] uvp_int;
  logic [N-1:0] oc_int;
  logic [N-1:0] lk_int;
  logic [N-1:0] uvp_stat;
  logic [N-1:0] oc_stat;
  logic [2*N-1:0] fcnt;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      ldo_supervisor_pkg::ch_state_t st;
      logic [TW-1:0] tmr;
      logic sflag;
      wire [2:0] slot = slots[3*i +: 3];
      wire [2:0] new_slot = wb_dat_i[3*i +: 3];
      wire uv = mon.under_voltage[i];
      wire oc = mon.overcurrent_fault[i];
      wire inlow = mon.input_low[i];
      wire hit = (seq_cnt == slot) && (slot != `SLOT_NONE) && (seq_tmr == '0);
      wire want = sys_en && chip_ok && ((slot == `SLOT_NONE) ? en[i] : sflag);
      wire powered = (st == ldo_supervisor_pkg::CH_START) || (st == ldo_supervisor_pkg::CH_RUN);
      wire uv_q = uv && tmr >= TW'(`UVP_QUAL_CYC - 1);
      wire oc_q = oc && tmr >= TW'(OC_QUAL_CYC - 1);
      wire run = (st == ldo_supervisor_pkg::CH_RUN);
      wire st_fail = (st == ldo_supervisor_pkg::CH_START) && uv &&
                     tmr >= TW'(START_WIN_CYC - 1) && !inhibit;
      wire fault = st_fail || (run && !inhibit && (uv_q || oc_q));
      wire last = fcnt[2*i +: 2] == `CH_FAULT_MAX - 2'h1;
      wire rewrite = (wr_en && wb_dat_i[i]) || (wr_slot && new_slot != slot);
      wire rs_done = tmr >= TW'(RESTART_CYC - 1);

      assign channel_on[i] = powered;
      assign uvp_stat[i] = powered && uv;
      assign oc_stat[i] = powered && oc;

      // Channel state, restart timer and fault counter
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          st <= ldo_supervisor_pkg::CH_OFF;
          tmr <= '0;
          sflag <= 1'b0;
          en[i] <= 1'b0;
          slots[3*i +: 3] <= `SLOT_NONE;
          fcnt[2*i +: 2] <= 2'h0;
          susd[i] <= 1'b0;
          uvp_int[i] <= 1'b0;
          oc_int[i] <= 1'b0;
          lk_int[i] <= 1'b0;
        end else begin
          if (rd_uvp) uvp_int[i] <= 1'b0;
          if (rd_oc) oc_int[i] <= 1'b0;
          if (rd_lock) lk_int[i] <= 1'b0;
          if (wr_en) en[i] <= wb_dat_i[i];
          if (wr_slot) slots[3*i +: 3] <= new_slot;
          if (seq_up && hit) sflag <= 1'b1;
          if (seq_down && hit) sflag <= 1'b0;
          if (!tmr[TW-1] || !(&tmr)) tmr <= tmr + TW'(1);
          if (!sys_en) begin
            st <= ldo_supervisor_pkg::CH_OFF;
            sflag <= 1'b0;
            fcnt[2*i +: 2] <= 2'h0;
            susd[i] <= 1'b0;
          end else if (rewrite) begin
            st <= ldo_supervisor_pkg::CH_OFF;
            fcnt[2*i +: 2] <= 2'h0;
            susd[i] <= 1'b0;
          end else begin
            case (st)
              ldo_supervisor_pkg::CH_OFF: begin
                tmr <= '0;
                if (want) begin
                  if (inlow) begin
                    st <= ldo_supervisor_pkg::CH_SUSP;
                    susd[i] <= 1'b1;
                    lk_int[i] <= 1'b1;
                  end else begin
                    st <= ldo_supervisor_pkg::CH_START;
                  end
                end
              end
              ldo_supervisor_pkg::CH_START,
              ldo_supervisor_pkg::CH_RUN: begin
                if (run && !uv && !oc) tmr <= '0;
                if (uv_q && run) uvp_int[i] <= 1'b1;
                if (oc_q && run) oc_int[i] <= 1'b1;
                if (!want) begin
                  st <= ldo_supervisor_pkg::CH_OFF;
                end else if (inlow) begin
                  st <= ldo_supervisor_pkg::CH_SUSP;
                  tmr <= '0;
                  susd[i] <= 1'b1;
                  lk_int[i] <= 1'b1;
                end else if (fault) begin
                  if (st_fail) uvp_int[i] <= 1'b1;
                  fcnt[2*i +: 2] <= fcnt[2*i +: 2] + 2'h1;
                  susd[i] <= 1'b1;
                  tmr <= '0;
                  if (last) begin
                    st <= ldo_supervisor_pkg::CH_OFF;
                    en[i] <= 1'b0;
                    slots[3*i +: 3] <= `SLOT_NONE;
                    sflag <= 1'b0;
                  end else begin
                    st <= ldo_supervisor_pkg::CH_SUSP;
                  end
                end else if (!run && !uv) begin
                  st <= ldo_supervisor_pkg::CH_RUN;
                  tmr <= '0;
                end
              end
              ldo_supervisor_pkg::CH_SUSP: begin
                if (!want) begin
                  st <= ldo_supervisor_pkg::CH_OFF;
                end else if (rs_done && !inlow) begin
                  st <= ldo_supervisor_pkg::CH_START;
                  susd[i] <= 1'b0;
                  tmr <= '0;
                end
              end
              default: begin
                st <= ldo_supervisor_pkg::CH_OFF;
              end
            endcase
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read mux and answer
  // ==========================================================
  wire seq_busy = !(seq_st == ldo_supervisor_pkg::SEQ_IDLE);
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    case (idx)
      `REG_CTRL: rmux = ctrl | (32'(seq_busy) << `CTRL_BUSY);
      `REG_ENABLE: rmux = 32'(en);
      `REG_SLOTS: rmux = 32'(slots);
      `REG_UVP_INT: rmux = 32'(uvp_int);
      `REG_OC_INT: rmux = 32'(oc_int);
      `REG_LOCK_INT: rmux = 32'(lk_int) | (32'(sys_int) << `LOCK_SYS_BIT) |
                           (32'(ot_int) << `LOCK_OT_BIT);
      `REG_STATUS: rmux = 32'(uvp_stat) | (32'(oc_stat) << `STAT_OC_LSB) |
                         (32'(mon.input_low) << `STAT_IN_LSB) |
                         (32'(mon.sys_lockout) << `STAT_SYS_BIT) |
                         (32'(mon.over_temp) << `STAT_OT_BIT);
      `REG_SUSPEND: rmux = 32'(susd) | (32'(!chip_ok) << `SUSP_CHIP_BIT);
      `REG_FCOUNT: rmux = 32'(fcnt) | (32'(chip_cnt) << `FCOUNT_CHIP_LSB);
      default: rmux = 32'h0;
    endcase
  end

  // One answer per request, a cycle after it; data and pin from flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      interrupt_out_n <= 1'b1;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= rd ? rmux : 32'h0;
      interrupt_out_n <= !(|uvp_int || |oc_int || |lk_int || sys_int || ot_int);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/ldo_supervisor_defines.svh ----
`ifndef LDO_SUPERVISOR_DEFINES_SVH
`define LDO_SUPERVISOR_DEFINES_SVH
`define NUM_CH 7
`define CLK_PERIOD_NS 25
`define UVP_QUAL_US 50
`define UVP_QUAL_CYC ((`UVP_QUAL_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTART_MS 20
`define RESTART_CYC ((`RESTART_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_WIN_MS 1
`define START_WIN_CYC ((`START_WIN_MS * 1000000) / `CLK_PERIOD_NS)
`define OC_QUAL_MS 1
`define OC_QUAL_CYC ((`OC_QUAL_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOT_US 1000
`define SLOT_CYC ((`SLOT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CH_FAULT_MAX 2'h3
`define CHIP_FAULT_MAX 3'h4
`define SLOT_W 3
`define SLOT_FIRST 3'h1
`define SLOT_LAST 3'h7
`define SLOT_NONE 3'h0
`define REG_CTRL 6'h00
`define REG_ENABLE 6'h01
`define REG_SLOTS 6'h02
`define REG_UVP_INT 6'h03
`define REG_OC_INT 6'h04
`define REG_LOCK_INT 6'h05
`define REG_STATUS 6'h06
`define REG_SUSPEND 6'h07
`define REG_FCOUNT 6'h08
`define CTRL_SYS_EN 0
`define CTRL_INHIBIT 1
`define CTRL_SEQ_LSB 4
`define CTRL_BUSY 8
`define SEQ_CMD_UP 2'h1
`define SEQ_CMD_DOWN 2'h2
`define LOCK_SYS_BIT 8
`define LOCK_OT_BIT 9
`define STAT_OC_LSB 8
`define STAT_IN_LSB 16
`define STAT_SYS_BIT 24
`define STAT_OT_BIT 25
`define SUSP_CHIP_BIT 8
`define FCOUNT_CHIP_LSB 16
`endif

// ---- hdl/ldo_supervisor_pkg.sv ----
`default_nettype none
package ldo_supervisor_pkg;
  // Analog comparator outputs, all asynchronous to sys_clk
  typedef struct packed {
    logic [6:0] under_voltage;
    logic [6:0] overcurrent_fault;
    logic [6:0] input_low;
    logic sys_lockout;
    logic over_temp;
  } monitor_t;
  typedef enum logic [3:0] {
    CH_OFF = 4'h1, CH_START = 4'h2, CH_RUN = 4'h4, CH_SUSP = 4'h8
  } ch_state_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1, SEQ_UP = 3'h2, SEQ_DOWN = 3'h4
  } seq_state_t;
  typedef enum logic [2:0] {
    CHIP_OK = 3'h1, CHIP_HOLD = 3'h2, CHIP_DEAD = 3'h4
  } chip_state_t;
endpackage
`default_nettype wire

// ---- testbench/rail_model.sv ----
`default_nettype none
module rail_model (
  input wire logic sys_clk,
  input wire logic [6:0] channel_on,
  input wire ldo_supervisor_pkg::monitor_t frc,
  input wire logic slow,
  output ldo_supervisor_pkg::monitor_t monitor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] age [7];
  // ==========
  // Rail ramp
  // Cycles since switch-on, saturating
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 7; i++) begin
      age[i] <= channel_on[i] ? age[i] + {6'h0, age[i] != 7'h7F} : 7'h00;
    end
  end
  // An off rail is discharged, so it reads under target too
  always_comb begin
    monitor = frc;
    monitor.overcurrent_fault = frc.overcurrent_fault & channel_on;
    for (int i = 0; i < 7; i++) begin
      monitor.under_voltage[i] = !channel_on[i] || age[i] < (slow ? 7'h28 : 7'h02)
        || frc.under_voltage[i];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ldo_supervisor_chk.sv ----
`default_nettype none
module ldo_supervisor_chk #(
  parameter int RESTART_CYC = 800000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ldo_supervisor_pkg::monitor_t monitor,
  input wire logic [6:0] channel_on,
  input wire logic interrupt_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Helpers
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctrl_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h00;
  wire rd_req = req && !wb_we_i;
  wire hot = monitor.over_temp || monitor.sys_lockout;
  logic inh;
  logic hot_d;
  logic [2:0] rd_age;
  logic [19:0] since;
  // Inhibit shadow; age counted from event start, not end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      inh <= 1'b0;
      hot_d <= 1'b0;
      rd_age <= 3'h7;
      since <= 20'hFFFFF;
    end else begin
      inh <= ctrl_wr ? wb_dat_i[1] : inh;
      hot_d <= hot;
      rd_age <= rd_req ? 3'h0 : rd_age + {2'h0, rd_age != 3'h7};
      since <= (hot && !hot_d) ? 20'h0 : since + {19'h0, since != 20'hFFFFF};
    end
  end
  // ==========
  // Properties
  property p_ack_next; req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_reset_off; $rose(reset_n) |-> channel_on == 7'h00 && interrupt_out_n; endproperty
  property p_sys_off; ctrl_wr && !wb_dat_i[0] |-> ##2 channel_on == 7'h00; endproperty
  property p_in_off;
    (monitor.input_low != 7'h00 && $stable(monitor.input_low)) [*5]
      |-> (channel_on & monitor.input_low) == 7'h00;
  endproperty
  property p_hot_off; hot [*5] |-> channel_on == 7'h00; endproperty
  property p_hot_hold;
    !inh && (channel_on & ~$past(channel_on)) != 7'h00 |-> since >= RESTART_CYC;
  endproperty
  property p_pin_release; $rose(interrupt_out_n) |-> rd_age < 3'h5; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  a_reset_off: assert property (p_reset_off)
    else $error("outputs active after reset");
  a_sys_off: assert property (p_sys_off)
    else $error("channels on after system disable");
  a_in_off: assert property (p_in_off)
    else $error("channel on with its input low");
  a_hot_off: assert property (p_hot_off)
    else $error("channels on during chip event");
  a_hot_hold: assert property (p_hot_hold)
    else $error("restart too soon after chip event");
  a_pin_release: assert property (p_pin_release)
    else $error("interrupt pin released without read");
  c_seq: cover property (ctrl_wr && wb_dat_i[5:4] == 2'h1);
  c_hot: cover property (hot [*5]);
  c_restart: cover property ($rose(channel_on[0]));
endmodule
`default_nettype wire

// ---- testbench/ldo_sequence_fault_supervisor_bench.sv ----
`default_nettype none
module ldo_sequence_fault_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST = 200;
  localparam int SL = 20;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic slow = 1'b0;
  ldo_supervisor_pkg::monitor_t frc = '0;
  ldo_supervisor_pkg::monitor_t mon;
  logic [6:0] ch_on;
  logic int_n;
  logic [31:0] q;
  int waited;
  int err_count = 0;
  int check_count = 0;
  // ==========
  // Clock, design and rails
  always #12.5 sys_clk = ~sys_clk;
  ldo_sequence_fault_supervisor #(.RESTART_CYC(RST), .START_WIN_CYC(50), .OC_QUAL_CYC(30),
    .SLOT_CYC(SL)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .monitor(mon), .channel_on(ch_on),
    .interrupt_out_n(int_n));
  rail_model u_rail (.sys_clk(sys_clk), .channel_on(ch_on), .frc(frc), .slow(slow),
    .monitor(mon));
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Request edge plus one: ack is sampled at the second edge
    chk(32'(n), 32'h2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wait_for(input logic [6:0] e, input int m);
    waited = 0;
    while (ch_on !== e && waited < m) begin
      @(posedge sys_clk);
      waited++;
    end
    chk({25'h0, ch_on}, {25'h0, e});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic print_verdict;
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk({24'h0, int_n, ch_on}, 32'h80);
    rd(8'h18, 32'h0);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'h3);
    wait_for(7'h03, 10);
    bus(1'b1, 8'h04, 32'h2);
    wait_for(7'h02, 3);
  endtask
  task automatic t_seq;
    bus(1'b1, 8'h08, 32'h640);
    bus(1'b1, 8'h00, 32'h11);
    wait_for(7'h06, 2 * SL);
    wait_for(7'h0E, 3 * SL);
    chk({31'h0, waited > 2 * SL - 6 && waited < 2 * SL + 5}, 32'h1);
    rd(8'h00, 32'h101);
    idle(5 * SL);
    bus(1'b1, 8'h08, 32'h642);
    bus(1'b1, 8'h00, 32'h11);
    wait_for(7'h0F, 3 * SL);
    idle(7 * SL);
    bus(1'b1, 8'h00, 32'h21);
    wait_for(7'h07, 6 * SL);
    bus(1'b1, 8'h04, 32'h0);
    wait_for(7'h05, 3);
    wait_for(7'h04, 2 * SL);
    wait_for(7'h00, 2 * SL);
    bus(1'b1, 8'h08, 32'h0);
  endtask
  task automatic t_uv;
    bus(1'b1, 8'h04, 32'h1);
    idle(20);
    frc.under_voltage[0] <= 1'b1;
    idle(1990);
    chk({25'h0, ch_on}, 32'h1);
    wait_for(7'h00, 40);
    rd(8'h1C, 32'h1);
    rd(8'h20, 32'h1);
    frc.under_voltage[0] <= 1'b0;
    slow <= 1'b1;
    idle(RST - 40);
    chk({24'h0, int_n, ch_on}, 32'h0);
    wait_for(7'h01, 60);
    idle(60);
    rd(8'h1C, 32'h0);
    rd(8'h0C, 32'h1);
    slow <= 1'b0;
    frc.under_voltage[0] <= 1'b1;
    wait_for(7'h00, 2100);
    wait_for(7'h01, RST + 40);
    wait_for(7'h00, 80);
    idle(400);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h3);
    rd(8'h1C, 32'h1);
    rd(8'h18, 32'h0);
    frc.under_voltage[0] <= 1'b0;
    bus(1'b1, 8'h04, 32'h1);
    wait_for(7'h01, 10);
    rd(8'h20, 32'h0);
    rd(8'h0C, 32'h1);
  endtask
  task automatic t_inhibit;
    bus(1'b1, 8'h00, 32'h3);
    frc.under_voltage[0] <= 1'b1;
    idle(2100);
    chk({24'h0, int_n, ch_on}, 32'h1);
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h1);
    rd(8'h20, 32'h0);
    frc.under_voltage[0] <= 1'b0;
    idle(5);
    rd(8'h18, 32'h0);
    frc.input_low[0] <= 1'b1;
    wait_for(7'h00, 6);
    rd(8'h18, 32'h10000);
    rd(8'h14, 32'h1);
    idle(RST);
    rd(8'h20, 32'h0);
    frc.input_low[0] <= 1'b0;
    wait_for(7'h01, 10);
    rd(8'h0C, 32'h1);
  endtask
  task automatic t_chip;
    bus(1'b1, 8'h00, 32'h1);
    // Overcurrent on a running channel qualifies, shuts, counts, restarts
    frc.overcurrent_fault[0] <= 1'b1;
    idle(3);
    rd(8'h18, 32'h100);
    wait_for(7'h00, 40);
    rd(8'h10, 32'h1);
    rd(8'h20, 32'h1);
    frc.overcurrent_fault[0] <= 1'b0;
    wait_for(7'h01, RST + 20);
    for (int k = 0; k < 2; k++) begin
      frc.over_temp <= !k[0];
      frc.sys_lockout <= k[0];
      wait_for(7'h00, 6);
      idle(3);
      frc <= '0;
      idle(RST - 30);
      chk({25'h0, ch_on}, 32'h0);
      wait_for(7'h01, 60);
      rd(8'h14, k[0] ? 32'h100 : 32'h200);
    end
    bus(1'b1, 8'h00, 32'h0);
    wait_for(7'h00, 3);
  endtask
  task automatic t_dead;
    bus(1'b1, 8'h00, 32'h1);
    wait_for(7'h01, 10);
    reset_n <= 1'b0;
    idle(2);
    chk({25'h0, ch_on}, 32'h0);
    reset_n <= 1'b1;
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wait_for(7'h01, RST + 30);
      frc.sys_lockout <= 1'b1;
      idle(6);
      frc.sys_lockout <= 1'b0;
    end
    idle(RST + 100);
    chk({25'h0, ch_on}, 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q & 32'h100, 32'h100);
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    idle(5);
    reset_n <= 1'b1;
    t_reset();
    t_seq();
    t_uv();
    t_inhibit();
    t_chip();
    t_dead();
    print_verdict();
  end
  initial begin
    idle(40000);
    err_count++;
    print_verdict();
  end
endmodule
bind ldo_sequence_fault_supervisor ldo_supervisor_chk #(.RESTART_CYC(RESTART_CYC)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .monitor(monitor), .channel_on(channel_on),
  .interrupt_out_n(interrupt_out_n));
`default_nettype wire
